// file: adc_pkg.sv
// Shared constants and types for the dual converter control and serial readout
package adc_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CONV_14_NS = 680;
   localparam int CONV_12_NS = 610;
   localparam int BUSY_RISE_NS = 40;
   localparam int SYNC_LAT = 4;
   localparam int CONV_14_CYC = CONV_14_NS / CLK_PERIOD_NS - SYNC_LAT;
   localparam int CONV_12_CYC = CONV_12_NS / CLK_PERIOD_NS - SYNC_LAT;
   localparam int QUIET_NS = 30;
   localparam int WAKE_US = 70;
   localparam int SCLK_MIN_KHZ = 10;
   localparam int SCLK_MAX_LO_MHZ = 35;
   localparam int SCLK_MAX_HI_MHZ = 48;
   localparam int RES_14 = 14;
   localparam int RES_12 = 12;
   localparam int FRAME_BITS = 28;
   localparam int CNT_W = 6;
   localparam int TIMER_W = 7;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic [13:0] a;
      logic [13:0] b;
   } sample_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } conv_state_t;
endpackage : adc_pkg

// file: adc_serial_core.sv
// Sample FIFO and the conversion and serial readout logic of the dual converter
// How it works
// - Busy falls no later than 680 ns (14-bit) or 610 ns (12-bit) after the convert-start falling edge.
// - Busy rises no later than 40 ns after the convert-start falling edge.
// - With chip select already low, the first result bit appears on the outputs as busy falls.
// - Both serial outputs are driven while chip select is low and released when it rises.
// - Each following bit is presented after a falling edge of the serial clock.
// - Results go out most significant bit first, 12 or 14 clocks each, both outputs at once.
// - After 14 more clocks each output carries the other result; on 12-bit parts each result is followed by two zeros.
`timescale 1ns/1ps

module sample_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] count;
      logic ready;
   } fifo_t;

   fifo_t r;
   fifo_t n;
   logic push;
   logic pop;

   always_comb begin
      n = r;
      push = in_valid_in && r.ready;
      pop = out_ready_in && (r.count != '0);
      if (push) begin
         n.mem[r.wr] = in_data_in;
         n.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
      end
      if (pop) begin
         n.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
      end
      n.count = r.count + CW'(push) - CW'(pop);
      n.ready = (n.count < CW'(DEPTH));
      if (reset_in) begin
         n = '0;
         n.ready = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      r <= n;
   end

   assign in_ready_out = r.ready;
   assign out_valid_out = (r.count != '0);
   assign out_data_out = r.mem[r.rd];
endmodule : sample_fifo

module adc_serial_core #(
   parameter logic WIDE_VARIANT = 1'b1
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic serial_clk_in,
   input wire logic convert_start_n_in,
   input wire logic chip_select_n_in,
   input wire logic sample_valid_in,
   input wire adc_pkg::sample_t sample_in,
   output logic sample_ready_out,
   output logic busy_out,
   output logic serial_out_a_out,
   output logic serial_out_a_oe_out,
   output logic serial_out_b_out,
   output logic serial_out_b_oe_out,
   output logic underrun_out
);
   typedef struct packed {
      logic [1:0] rst_s;
      logic [adc_pkg::CNT_W-1:0] bin;
      logic [adc_pkg::CNT_W-1:0] gray;
   } link_t;

   typedef struct packed {
      adc_pkg::conv_state_t st;
      logic [adc_pkg::TIMER_W-1:0] timer;
      logic [2:0] cnv_s;
      logic cnv_f;
      logic [2:0] cs_s;
      logic cs_f;
      logic [2:0][adc_pkg::CNT_W-1:0] g_s;
      logic [adc_pkg::CNT_W-1:0] cnt_f;
      logic [adc_pkg::CNT_W-1:0] base;
      adc_pkg::sample_t result;
      logic busy;
      logic da;
      logic db;
      logic oe;
      logic underrun;
   } sys_t;

   localparam logic [adc_pkg::TIMER_W-1:0] CONV_LOAD = WIDE_VARIANT ?
      adc_pkg::TIMER_W'(adc_pkg::CONV_14_CYC - 1) : adc_pkg::TIMER_W'(adc_pkg::CONV_12_CYC - 1);

   function automatic logic [adc_pkg::CNT_W-1:0] gray_to_bin(input logic [adc_pkg::CNT_W-1:0] g);
      logic [adc_pkg::CNT_W-1:0] b;
      b = '0;
      b[adc_pkg::CNT_W - 1] = g[adc_pkg::CNT_W - 1];
      for (int i = adc_pkg::CNT_W - 2; i >= 0; i--) begin
         b[i] = g[i] ^ b[i + 1];
      end
      return b;
   endfunction : gray_to_bin

   function automatic logic frame_bit(input adc_pkg::sample_t s, input logic [adc_pkg::CNT_W-1:0] idx,
                                      input logic b_first);
      logic [13:0] p;
      logic [13:0] q;
      logic [adc_pkg::FRAME_BITS-1:0] f;
      p = b_first ? s.b : s.a;
      q = b_first ? s.a : s.b;
      if (WIDE_VARIANT) begin
         f = {p, q};
      end else begin
         f = {p[adc_pkg::RES_12-1:0], 2'b00, q[adc_pkg::RES_12-1:0], 2'b00};
      end
      if (idx < adc_pkg::CNT_W'(adc_pkg::FRAME_BITS)) begin
         return f[5'(adc_pkg::FRAME_BITS - 1) - idx[4:0]];
      end
      return 1'b0;
   endfunction : frame_bit

   link_t lr;
   link_t ln;
   sys_t r;
   sys_t n;
   logic cnv_fall;
   logic cs_fall;
   logic pop;
   logic fifo_valid;
   adc_pkg::sample_t fifo_data;
   logic [adc_pkg::CNT_W-1:0] idx;

   // Falling-edge counter on the host's serial clock
   always_comb begin
      ln = lr;
      ln.rst_s = {lr.rst_s[0], reset_in};
      ln.bin = lr.bin + 1'b1;
      if (lr.rst_s[1]) begin
         ln.bin = '0;
      end
      ln.gray = ln.bin ^ (ln.bin >> 1);
   end

   always_ff @(negedge serial_clk_in) begin
      lr <= ln;
   end

   sample_fifo #(
      .WIDTH(2 * adc_pkg::RES_14),
      .DEPTH(adc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .in_valid_in(sample_valid_in),
      .in_data_in(sample_in),
      .in_ready_out(sample_ready_out),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(pop)
   );

   always_comb begin
      n = r;
      n.cnv_s = {r.cnv_s[1:0], convert_start_n_in};
      n.cs_s = {r.cs_s[1:0], chip_select_n_in};
      n.g_s = {r.g_s[1:0], lr.gray};
      if (r.cnv_s[1] == r.cnv_s[2]) begin
         n.cnv_f = r.cnv_s[2];
      end
      if (r.cs_s[1] == r.cs_s[2]) begin
         n.cs_f = r.cs_s[2];
      end
      if (r.g_s[1] == r.g_s[2]) begin
         n.cnt_f = gray_to_bin(r.g_s[2]);
      end
      cnv_fall = r.cnv_f && !n.cnv_f;
      cs_fall = r.cs_f && !n.cs_f;
      pop = 1'b0;
      if (cs_fall) begin
         n.base = n.cnt_f;
      end
      case (r.st)
         adc_pkg::ST_IDLE: begin
            if (cnv_fall) begin
               n.st = adc_pkg::ST_CONV;
               n.busy = 1'b1;
               n.timer = CONV_LOAD;
               pop = fifo_valid;
               n.result = fifo_valid ? fifo_data : '0;
               n.underrun = !fifo_valid;
            end
         end
         adc_pkg::ST_CONV: begin
            // Further convert-start edges are ignored here
            if (r.timer == '0) begin
               n.st = adc_pkg::ST_IDLE;
               n.busy = 1'b0;
            end else begin
               n.timer = r.timer - 1'b1;
            end
         end
         default: begin
            n.st = adc_pkg::ST_IDLE;
            n.busy = 1'b0;
         end
      endcase
      idx = n.cnt_f - n.base;
      n.oe = !n.cs_f;
      if (n.busy || n.cs_f) begin
         n.da = 1'b0;
         n.db = 1'b0;
      end else begin
         n.da = frame_bit(n.result, idx, 1'b0);
         n.db = frame_bit(n.result, idx, 1'b1);
      end
      if (reset_in) begin
         n = '0;
         n.st = adc_pkg::ST_IDLE;
         n.cnv_s = 3'h7;
         n.cnv_f = 1'b1;
         n.cs_s = 3'h7;
         n.cs_f = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      r <= n;
   end

   assign busy_out = r.busy;
   assign serial_out_a_out = r.da;
   assign serial_out_b_out = r.db;
   assign serial_out_a_oe_out = r.oe;
   assign serial_out_b_oe_out = r.oe;
   assign underrun_out = r.underrun;
endmodule : adc_serial_core

// file: adc_serial_checker.sv
// Concurrent checks on the converter ports
`timescale 1ns/1ps
module adc_serial_checker (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic convert_start_n_in,
   input wire logic chip_select_n_in,
   input wire logic busy_out,
   input wire logic serial_out_a_out,
   input wire logic serial_out_a_oe_out,
   input wire logic serial_out_b_out,
   input wire logic serial_out_b_oe_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   a_busy_rise: assert property ($fell(convert_start_n_in) && !busy_out |-> ##[1:5] busy_out)
      else $error("busy rose late");
   a_conv_end: assert property ($fell(convert_start_n_in) && !busy_out |-> ##[5:85] $fell(busy_out))
      else $error("conversion too long");
   a_busy_quiet: assert property (busy_out && $past(busy_out) |-> !serial_out_a_out && !serial_out_b_out)
      else $error("data during busy");
   a_oe_on: assert property ($fell(chip_select_n_in) |-> ##[1:5] serial_out_a_oe_out && serial_out_b_oe_out)
      else $error("outputs not enabled");
   a_oe_off: assert property ($rose(chip_select_n_in) |-> ##[1:5] !(serial_out_a_oe_out || serial_out_b_oe_out))
      else $error("outputs not released");
   a_oe_pair: assert property (serial_out_a_oe_out == serial_out_b_oe_out)
      else $error("enables differ");
   a_oe_stay: assert property ((!chip_select_n_in) [*6] |-> serial_out_a_oe_out)
      else $error("enable dropped");
endmodule : adc_serial_checker
bind adc_serial_core adc_serial_checker adc_serial_checker_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
   .convert_start_n_in(convert_start_n_in), .chip_select_n_in(chip_select_n_in), .busy_out(busy_out),
   .serial_out_a_out(serial_out_a_out), .serial_out_a_oe_out(serial_out_a_oe_out),
   .serial_out_b_out(serial_out_b_out), .serial_out_b_oe_out(serial_out_b_oe_out));

// file: host_model.sv
// Host model driving convert start and the serial read port
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk_in,
   input wire logic busy_in,
   input wire logic pin_a_in,
   input wire logic pin_b_in,
   output logic serial_clk_out,
   output logic convert_start_n_out,
   output logic chip_select_n_out
);
   initial begin
      serial_clk_out = 1'b1;
      convert_start_n_out = 1'b1;
      chip_select_n_out = 1'b1;
   end
   // Link counter leaves its unknown start only on falling edges seen under reset
   task automatic warm(input integer pulses);
      integer k;
      for (k = 0; k < pulses; k++) begin
         serial_clk_out = 1'b0;
         #16;
         serial_clk_out = 1'b1;
         #16;
      end
   endtask : warm
   task automatic frame(input logic early, output logic msb, output logic [27:0] da, output logic [27:0] db);
      integer k;
      @(posedge sys_clk_in);
      chip_select_n_out <= ~early;
      convert_start_n_out <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      convert_start_n_out <= 1'b1;
      for (k = 0; k < 120 && busy_in !== 1'b0; k++) @(negedge sys_clk_in);
      msb = pin_a_in;
      @(posedge sys_clk_in);
      chip_select_n_out <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      #3;
      for (k = 0; k < 28; k++) begin
         serial_clk_out = 1'b0;
         #16;
         da[27-k] = pin_a_in;
         db[27-k] = pin_b_in;
         serial_clk_out = 1'b1;
         #16;
      end
      @(posedge sys_clk_in);
      chip_select_n_out <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
   endtask : frame
endmodule : host_model

// file: testbench.sv
// Self-checking bench for the converter block
`timescale 1ns/1ps
module testbench;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic valid_r = 1'b0;
   adc_pkg::sample_t data_r = '0;
   adc_pkg::sample_t q[$];
   adc_pkg::sample_t exp_s;
   integer n_fail = 0, total_checks = 0, seed = 32'hbd5d, cyc = 0, i;
   logic [27:0] da, db;
   logic msb;
   wire logic sclk, cnv_n, cs_n, rdy, busy, a_o, a_oe, b_o, b_oe, unr;
   initial forever #4 sys_clk_in = ~sys_clk_in;
   adc_serial_core adc_serial_core_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .serial_clk_in(sclk),
      .convert_start_n_in(cnv_n), .chip_select_n_in(cs_n), .sample_valid_in(valid_r), .sample_in(data_r),
      .sample_ready_out(rdy), .busy_out(busy), .serial_out_a_out(a_o), .serial_out_a_oe_out(a_oe),
      .serial_out_b_out(b_o), .serial_out_b_oe_out(b_oe), .underrun_out(unr));
   host_model host_model_inst (.sys_clk_in(sys_clk_in), .busy_in(busy), .pin_a_in(a_oe ? a_o : 1'b1),
      .pin_b_in(b_oe ? b_o : 1'b1), .serial_clk_out(sclk), .convert_start_n_out(cnv_n), .chip_select_n_out(cs_n));
   task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      #1;
      host_model_inst.warm(6);
   end
   initial begin
      repeat (10) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      valid_r <= 1'b1;
      for (i = 0; i < 20; i++) begin
         data_r <= 28'($random(seed));
         @(negedge sys_clk_in);
         if (rdy === 1'b1) q.push_back(data_r);
         @(posedge sys_clk_in);
      end
      valid_r <= 1'b0;
      @(negedge sys_clk_in);
      check("fill", 28'(q.size()), 28'h10);
      check("ready", rdy, 28'h0);
      $display("test fill done");
      repeat (adc_pkg::WAKE_US * 1000 / adc_pkg::CLK_PERIOD_NS) @(posedge sys_clk_in);
      for (i = 0; i < 17; i++) begin
         host_model_inst.frame(i[0], msb, da, db);
         exp_s = q.size() > 0 ? q.pop_front() : '0;
         check("pin a", da, {exp_s.a, exp_s.b});
         check("pin b", db, {exp_s.b, exp_s.a});
         if (i[0]) check("msb", msb, exp_s.a[13]);
         check("underrun", unr, i == 16);
         $display("test frame %0d done", i);
      end
      check("ready", rdy, 28'h1);
      stop_test();
   end
endmodule : testbench
